//--- rtl/otc_pkg.sv
/*
 Shared constants for the oscillator time counter chain: register offsets,
 widths and the counts of the fixed divider stage.
 Assumes a single 20 MHz clock standing in for the oscillator clock.
*/
package otc_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W  = 16;
    localparam int ADDR_W  = 16;

    // ==========================================================
    // Register byte offsets
    localparam logic [15:0] OFF_RELOAD     = 16'hf0d0;
    localparam logic [15:0] OFF_PRESCALE   = 16'hf0d2;
    localparam logic [15:0] OFF_TIME_LOW   = 16'hf0d4;
    localparam logic [15:0] OFF_TIME_HIGH  = 16'hf0d6;
    localparam logic [15:0] OFF_SUBNODE    = 16'hf0d8;
    localparam logic [15:0] OFF_NODE       = 16'hf0da;

    // ==========================================================
    // Subnode control and node bit positions
    localparam int SUB_CLK_REQ_BIT  = 0;
    localparam int SUB_CLK_EN_BIT   = 1;
    localparam int SUB_FLT_REQ_BIT  = 2;
    localparam int SUB_FLT_EN_BIT   = 3;
    localparam int NODE_REQ_BIT     = 0;
    localparam int NODE_EN_BIT      = 1;

    // ==========================================================
    // Fixed divider stage
    localparam int          DIV_RATIO = 8;
    localparam logic [2:0]  DIV_LAST  = 3'h7;

    // ==========================================================
    // Reset values of control bits
    localparam logic [1:0]  SUB_EN_RESET  = 2'h0;
    localparam logic        NODE_RESET    = 1'b0;

    // Word type
    typedef logic [DATA_W-1:0] otc_word_type;

endpackage

//--- rtl/otc_if.sv
/*
 Interface joining the timekeeping device and its host side.
 Assumes both ends share clk_i; the testbench binds them.
*/
`timescale 1ns/10ps
interface otc_if;
    // Register port
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        ack;
    // Interrupt path
    logic        irq;
    logic        irq_vector;
    // Power state
    logic        idle;
    logic        power_down;
    logic        run_in_power_down;

    modport device
    (
        input  req, we, addr, wdata, irq_vector, idle, power_down, run_in_power_down,
        output rdata, ack, irq
    );
    modport host
    (
        output req, we, addr, wdata, irq_vector, idle, power_down, run_in_power_down,
        input  rdata, ack, irq
    );
endinterface

//--- rtl/otc_divider.sv
/*
 Fixed divide-by-eight stage producing a one-cycle enable pulse.
 Assumes the oscillator clock runs without stopping.
*/
`timescale 1ns/10ps
module otc_divider
(
    // Clock
    input  wire logic clk_i,
    // Control
    input  wire logic run_i,
    // Pulse
    output logic      tick_o
);
    logic [2:0] count_reg;

    // ==========================================================
    // Count; no reset, the chain survives every reset
    // Unknown power-on count takes the wrap branch and settles at once
    always_ff @(posedge clk_i)
    begin
        if (run_i)
        begin
            if (count_reg != otc_pkg::DIV_LAST)
                count_reg <= count_reg + 3'h1;
            else
                count_reg <= 3'h0;
        end
    end

    assign tick_o = run_i && (count_reg == otc_pkg::DIV_LAST);
endmodule

//--- rtl/otc_device.sv
/*
 Timekeeping counter chain with its register port and shared interrupt
 node with subnode gating.
 Assumes host requests are held until ack; one clock for all logic.
*/
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
module otc_device
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Link
    otc_if.device     bus,
    // Oscillator fault source of the shared node
    input  wire logic fault_event_i
);
    typedef enum logic [1:0] {ST_IDLE, ST_ACK} otc_bus_state_type;

    otc_pkg::otc_word_type reload_reg;
    otc_pkg::otc_word_type prescale_reg;
    otc_pkg::otc_word_type time_low_reg;
    otc_pkg::otc_word_type time_high_reg;
    logic [1:0]            sub_en_reg;
    logic                  clk_req_reg;
    logic                  flt_req_reg;
    logic                  node_en_reg;
    logic                  node_req_reg;
    otc_pkg::otc_word_type rdata_reg;
    otc_bus_state_type     state_reg;

    logic run;
    logic tick;
    logic ovf;
    logic low_wrap;
    logic wr;
    logic sub_wr;
    logic event_any;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    // ==========================================================
    // Divider stage; runs from the free oscillator clock
    assign run = !bus.power_down || bus.run_in_power_down;

    otc_divider u_div
    (
        .clk_i  (clk_i),
        .run_i  (run),
        .tick_o (tick)
    );

    // ==========================================================
    // Register strobes
    assign wr       = (state_reg == ST_IDLE) && bus.req && bus.we;
    assign ovf      = tick && (prescale_reg == 16'hffff);
    assign low_wrap = ovf && (time_low_reg == 16'hffff);

    // ==========================================================
    // Prescale timer; reload from zero spans 2^16 ticks
    always_ff @(posedge clk_i)
    begin
        if (wr && hit(bus.addr, otc_pkg::OFF_PRESCALE))
            prescale_reg <= bus.wdata;
        else if (ovf)
            prescale_reg <= reload_reg;
        else if (tick)
            prescale_reg <= prescale_reg + 16'h1;
    end

    // Reload register; no reset by design
    always_ff @(posedge clk_i)
    begin
        if (wr && hit(bus.addr, otc_pkg::OFF_RELOAD))
            reload_reg <= bus.wdata;
    end

    // Low time word
    always_ff @(posedge clk_i)
    begin
        if (wr && hit(bus.addr, otc_pkg::OFF_TIME_LOW))
            time_low_reg <= bus.wdata;
        else if (ovf)
            time_low_reg <= time_low_reg + 16'h1;
    end

    // High time word
    always_ff @(posedge clk_i)
    begin
        if (wr && hit(bus.addr, otc_pkg::OFF_TIME_HIGH))
            time_high_reg <= bus.wdata;
        else if (low_wrap)
            time_high_reg <= time_high_reg + 16'h1;
    end

    // ==========================================================
    // Subnode control; set beats a software clear
    assign sub_wr = wr && hit(bus.addr, otc_pkg::OFF_SUBNODE);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sub_en_reg <= otc_pkg::SUB_EN_RESET;
        else if (sub_wr)
            sub_en_reg <= {bus.wdata[otc_pkg::SUB_FLT_EN_BIT], bus.wdata[otc_pkg::SUB_CLK_EN_BIT]};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            clk_req_reg <= 1'b0;
        else if (ovf)
            clk_req_reg <= 1'b1;
        else if (sub_wr)
            clk_req_reg <= bus.wdata[otc_pkg::SUB_CLK_REQ_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flt_req_reg <= 1'b0;
        else if (fault_event_i)
            flt_req_reg <= 1'b1;
        else if (sub_wr)
            flt_req_reg <= bus.wdata[otc_pkg::SUB_FLT_REQ_BIT];
    end

    // ==========================================================
    // Shared node; request raised by any enabled source event
    assign event_any = (ovf && sub_en_reg[0]) || (fault_event_i && sub_en_reg[1]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            node_en_reg <= otc_pkg::NODE_RESET;
        else if (wr && hit(bus.addr, otc_pkg::OFF_NODE))
            node_en_reg <= bus.wdata[otc_pkg::NODE_EN_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            node_req_reg <= otc_pkg::NODE_RESET;
        else if (event_any)
            node_req_reg <= 1'b1;
        else if (bus.irq_vector)
            node_req_reg <= 1'b0;
        else if (wr && hit(bus.addr, otc_pkg::OFF_NODE))
            node_req_reg <= bus.wdata[otc_pkg::NODE_REQ_BIT];
    end

    assign bus.irq = node_req_reg && node_en_reg;

    // ==========================================================
    // Register port: answer one cycle after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_reg <= ST_IDLE;
        else
        begin
            unique case (state_reg)
                ST_IDLE: if (bus.req) state_reg <= ST_ACK;
                ST_ACK:  state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_reg <= 16'h0;
        else if (state_reg == ST_IDLE && bus.req && !bus.we)
        begin
            unique case (bus.addr)
                otc_pkg::OFF_RELOAD:    rdata_reg <= reload_reg;
                otc_pkg::OFF_PRESCALE:  rdata_reg <= prescale_reg;
                otc_pkg::OFF_TIME_LOW:  rdata_reg <= time_low_reg;
                otc_pkg::OFF_TIME_HIGH: rdata_reg <= time_high_reg;
                otc_pkg::OFF_SUBNODE:   rdata_reg <= {12'h0, sub_en_reg[1], flt_req_reg, sub_en_reg[0], clk_req_reg};
                otc_pkg::OFF_NODE:      rdata_reg <= {14'h0, node_en_reg, node_req_reg};
                default:                rdata_reg <= 16'h0;
            endcase
        end
    end

    assign bus.ack   = (state_reg == ST_ACK);
    assign bus.rdata = rdata_reg;
endmodule

//--- rtl/otc_host.sv
/*
 Host end: takes software orders over classic Wishbone, drives the device
 register port, and reports the device's interrupt and answers.
 Assumes the device answers every request.
*/
`timescale 1ns/10ps
module otc_host
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Processor side
    input  wire logic        vector_i,
    input  wire logic        idle_i,
    input  wire logic        power_down_i,
    input  wire logic        run_in_power_down_i,
    output logic             irq_o,
    // Link
    otc_if.host              bus
);
    typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_DONE} otc_host_state_type;

    otc_host_state_type state_reg;
    logic [31:0]        dat_reg;

    // ==========================================================
    // Forward request while waiting; low half-word lanes carry data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_reg <= HS_IDLE;
        else
        begin
            unique case (state_reg)
                HS_IDLE: if (cyc_i && stb_i) state_reg <= HS_WAIT;
                HS_WAIT: if (bus.ack) state_reg <= HS_DONE;
                HS_DONE: state_reg <= HS_IDLE;
                default: state_reg <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_reg <= 32'h0;
        else if (state_reg == HS_WAIT && bus.ack)
            dat_reg <= {16'h0, bus.rdata};
    end

    // Writes without both low lanes selected are passed as reads, storing nothing
    assign bus.req   = (state_reg == HS_WAIT);
    assign bus.we    = we_i && (sel_i[1:0] == 2'h3);
    assign bus.addr  = adr_i;
    assign bus.wdata = dat_i[15:0];
    assign bus.irq_vector        = vector_i;
    assign bus.idle              = idle_i;
    assign bus.power_down        = power_down_i;
    assign bus.run_in_power_down = run_in_power_down_i;

    assign ack_o = (state_reg == HS_DONE);
    assign dat_o = dat_reg;
    assign irq_o = bus.irq;
endmodule

//--- verif/otc_monitor.sv
/*
 Checker for the link between the host and device ends.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module otc_monitor
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Link
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] rdata,
    input  wire logic        ack,
    input  wire logic        irq,
    input  wire logic        irq_vector
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ==========================================================
    // Handshake
    ack_has_req_a: assert property (ack |-> req)
        else $error("ack without request");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    req_answer_a: assert property ($rose(req) |=> ack)
        else $error("request not answered next cycle");
    req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    req_drop_a: assert property (ack |=> !req)
        else $error("request kept after ack");
    rdata_move_a: assert property ($changed(rdata) |-> ack || $past(rst_i))
        else $error("read data moved without ack");

    // ==========================================================
    // Interrupt; falls only by vector, a register write or reset
    irq_fall_a: assert property ($fell(irq) |-> $past(irq_vector) || $past(irq_vector, 2) || ack)
        else $error("irq dropped without cause");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack && !irq)
        else $error("ack or irq after reset");

    cover property (ack && we);
    cover property (ack && !we);
    cover property ($rose(irq));
    cover property (irq && irq_vector);
endmodule

//--- verif/testbench.sv
/*
 Self-checking bench: Wishbone master on the host end, device end joined
 over the link. Assumes otc_pkg, otc_if and both ends compiled first.
*/
`timescale 1ns/10ps
module testbench;
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        cyc         = 1'b0;
    logic        stb         = 1'b0;
    logic        we          = 1'b0;
    logic [15:0] adr         = 16'h0;
    logic [31:0] dw          = 32'h0;
    logic [3:0]  sel         = 4'h0;
    logic [31:0] dr;
    logic        ack;
    logic        irq;
    logic        vec         = 1'b0;
    logic        idle        = 1'b0;
    logic        pdn         = 1'b0;
    logic        run_pd      = 1'b0;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          cycles      = 0;

    always #25 clk_i = ~clk_i;

    otc_if bus();
    otc_device i_otc_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .fault_event_i(1'b0));
    otc_host i_otc_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .sel_i(sel), .adr_i(adr), .dat_i(dw), .dat_o(dr), .ack_o(ack), .vector_i(vec),
        .idle_i(idle), .power_down_i(pdn), .run_in_power_down_i(run_pd), .irq_o(irq), .bus(bus));
    otc_monitor i_otc_monitor (.clk_i(clk_i), .rst_i(rst_i), .req(bus.req), .we(bus.we),
        .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack), .irq(bus.irq),
        .irq_vector(bus.irq_vector));

    // ==========================================================
    // Verdict and hang guard
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // ==========================================================
    // Bus cycles and compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        dw <= {16'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hf, q);
    endtask

    // Mask hides the bits a running counter may move
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic [15:0] m);
        logic [31:0] q;
        wb(1'b0, a, 16'h0, 4'hf, q);
        chk(q & {16'h0, m}, {16'h0, exp & m});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] q;
        wr(otc_pkg::OFF_PRESCALE, 16'h0000);
        wr(otc_pkg::OFF_RELOAD, 16'h1234);
        wr(otc_pkg::OFF_TIME_LOW, 16'h0042);
        rd_chk(otc_pkg::OFF_RELOAD, 16'h1234, 16'hffff);
        // Write with the low lanes unselected must store nothing
        wb(1'b1, otc_pkg::OFF_RELOAD, 16'h9999, 4'hc, q);
        rd_chk(otc_pkg::OFF_RELOAD, 16'h1234, 16'hffff);
        rd_chk(otc_pkg::OFF_TIME_LOW, 16'h0042, 16'hffff);
        wr(16'hf0e0, 16'h5555);
        rd_chk(16'hf0e0, 16'h0000, 16'hffff);
    endtask

    task automatic t_chain();
        wr(otc_pkg::OFF_NODE, 16'h0002);
        wr(otc_pkg::OFF_SUBNODE, 16'h0002);
        wr(otc_pkg::OFF_RELOAD, 16'h0000);
        wr(otc_pkg::OFF_TIME_HIGH, 16'h0005);
        wr(otc_pkg::OFF_TIME_LOW, 16'hffff);
        wr(otc_pkg::OFF_PRESCALE, 16'hfffe);
        while (irq !== 1'b1)
            @(posedge clk_i);
        rd_chk(otc_pkg::OFF_TIME_HIGH, 16'h0006, 16'hffff);
        rd_chk(otc_pkg::OFF_TIME_LOW, 16'h0000, 16'hffff);
        rd_chk(otc_pkg::OFF_PRESCALE, 16'h0000, 16'hfff0);
        rd_chk(otc_pkg::OFF_SUBNODE, 16'h0003, 16'h0003);
        @(posedge clk_i);
        vec <= 1'b1;
        @(posedge clk_i);
        vec <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        rd_chk(otc_pkg::OFF_SUBNODE, 16'h0001, 16'h0001);
        // Subnode enable off: flag still sets, no interrupt
        wr(otc_pkg::OFF_SUBNODE, 16'h0000);
        wr(otc_pkg::OFF_PRESCALE, 16'hffff);
        repeat (40) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        rd_chk(otc_pkg::OFF_SUBNODE, 16'h0001, 16'h0003);
    endtask

    task automatic t_power();
        pdn <= 1'b1;
        wr(otc_pkg::OFF_PRESCALE, 16'h0100);
        repeat (40) @(posedge clk_i);
        rd_chk(otc_pkg::OFF_PRESCALE, 16'h0100, 16'hffff);
        run_pd <= 1'b1;
        idle <= 1'b1;
        wr(otc_pkg::OFF_PRESCALE, 16'h0100);
        repeat (40) @(posedge clk_i);
        rd_chk(otc_pkg::OFF_PRESCALE, 16'h0104, 16'hfffc);
        pdn <= 1'b0;
        idle <= 1'b0;
    endtask

    task automatic t_carry();
        logic [31:0] hi_a;
        logic [31:0] hi_b;
        logic [31:0] lo;
        wr(otc_pkg::OFF_TIME_HIGH, 16'h0010);
        wr(otc_pkg::OFF_TIME_LOW, 16'hffff);
        wr(otc_pkg::OFF_PRESCALE, 16'hffff);
        // High, low, high again; a moved high word means a carry, so low is read anew
        wb(1'b0, otc_pkg::OFF_TIME_HIGH, 16'h0, 4'hf, hi_a);
        wb(1'b0, otc_pkg::OFF_TIME_LOW, 16'h0, 4'hf, lo);
        wb(1'b0, otc_pkg::OFF_TIME_HIGH, 16'h0, 4'hf, hi_b);
        if (hi_a !== hi_b)
            wb(1'b0, otc_pkg::OFF_TIME_LOW, 16'h0, 4'hf, lo);
        chk({hi_b[15:0], lo[15:0]}, 32'h0011_0000);
        // Software trim of the count by one
        wr(otc_pkg::OFF_TIME_LOW, lo[15:0] + 16'h1);
        rd_chk(otc_pkg::OFF_TIME_LOW, 16'h0001, 16'hffff);
    endtask

    task automatic t_reset();
        wr(otc_pkg::OFF_TIME_HIGH, 16'h00a5);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(otc_pkg::OFF_TIME_HIGH, 16'h00a5, 16'hffff);
    endtask

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_chain();
        t_power();
        t_carry();
        t_reset();
        print_verdict();
    end
endmodule
